// ---- core/dac_pkg.sv ----
// package of the demand averaging block: register map, field positions, sizes
// assumes a single clock domain and one sample strobe shared by both channels
package dac_pkg;
   // -------------------------------------------------------------
   // sizes
   // -------------------------------------------------------------
   localparam int SAMP_W   = 16;
   localparam int SUM_W    = 32;
   localparam int CNT_W    = 16;
   localparam int RING_AW  = 4;
   localparam int RING_D   = 16;
   localparam int LG_MAX   = 4;
   localparam int DIV_STEPS = 32;
   localparam int NCH      = 2;
   localparam int CH_VOLT  = 0;
   localparam int CH_POWER = 1;

   // -------------------------------------------------------------
   // register offsets (byte addresses)
   // -------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL      = 8'h00;
   localparam logic [7:0] OFS_VOLT_DUR  = 8'h04;
   localparam logic [7:0] OFS_POWER_DUR = 8'h08;
   localparam logic [7:0] OFS_CMD       = 8'h0c;
   localparam logic [7:0] OFS_VOLT_AVG  = 8'h10;
   localparam logic [7:0] OFS_POWER_AVG = 8'h14;
   localparam logic [7:0] OFS_POWER_PK  = 8'h18;
   localparam logic [7:0] OFS_STATUS    = 8'h1c;

   // -------------------------------------------------------------
   // fields
   // -------------------------------------------------------------
   // ctrl: per channel c, bit 2c = sliding window, bit 2c+1 = edge triggered period
   localparam int CTRL_SLIDE_BIT = 0;
   localparam int CTRL_EDGE_BIT  = 1;
   localparam int CTRL_W         = 4;
   // duration: [15:0] fixed period in samples, [18:16] log2 of sliding length
   localparam int DUR_LG_LSB     = 16;
   localparam int DUR_W          = 19;
   // cmd: bit c clears channel c
   localparam int CMD_W          = 2;
   // status: [1:0] divider busy, [3:2] edge armed, [5:4] sliding window full
   localparam int STAT_BUSY_LSB  = 0;
   localparam int STAT_ARM_LSB   = 2;
   localparam int STAT_FULL_LSB  = 4;

   // -------------------------------------------------------------
   // reset values
   // -------------------------------------------------------------
   localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
   localparam logic [DUR_W-1:0]  DUR_RST  = 19'h40010;
endpackage : dac_pkg

// ---- core/dac_ring_mem.sv ----
// sample history for the sliding window, one write and one registered read port
// assumes a read of the word being written in the same cycle may return its old content
`timescale 1ns/1ps
module dac_ring_mem #(
   parameter int W  = 16,
   parameter int AW = 4
) (
   input  wire logic          clk_in,
   input  wire logic          rst_n_in,
   input  wire logic          we_in,
   input  wire logic [AW-1:0] waddr_in,
   input  wire logic [W-1:0]  wdata_in,
   input  wire logic [AW-1:0] raddr_in,
   output logic      [W-1:0]  rdata_out
);
   logic [W-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge clk_in) begin
      if (we_in) begin
         mem[waddr_in] <= wdata_in;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_out <= '0;
      end else begin
         rdata_out <= mem[raddr_in];
      end
   end
endmodule : dac_ring_mem

// ---- core/dac_core.sv ----
// demand averaging for a voltage and a power channel, with peak demand on power
// assumes sample_valid_in strobes at least 40 cycles apart; inputs synchronous to clk_in
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
// Function
// - sliding mode averages the most recent window (duration source only; edge source overrides it)
// - fixed mode restarts average after each period
// - duration source takes period from per-channel setting
// - edge source averages between successive trigger rises
// - assigned clear input rising edge clears channel
// - direct command bit c clears channel c (voltage or power) one cycle after the write
// - power keeps peaks; its clear wipes both
module dac_core
   import dac_pkg::*;
(
   input  wire logic              clk_in,
   input  wire logic              rst_n_in,
   input  wire logic [7:0]        addr_in,
   input  wire logic [31:0]       wdata_in,
   input  wire logic              wr_in,
   input  wire logic              rd_in,
   output logic      [31:0]       rdata_out,
   input  wire logic              sample_valid_in,
   input  wire logic [SAMP_W-1:0] voltage_sample_in,
   input  wire logic [SAMP_W-1:0] power_sample_in,
   input  wire logic              voltage_period_trigger_input,
   input  wire logic              power_period_trigger_input,
   input  wire logic              voltage_average_clear,
   input  wire logic              power_demand_clear
);
   // -------------------------------------------------------------
   // configuration registers
   // -------------------------------------------------------------
   logic [CTRL_W-1:0]          ctrl;
   logic [NCH-1:0][DUR_W-1:0]  dur;
   logic [NCH-1:0]             cmd_clr;
   logic [NCH-1:0][SAMP_W-1:0] samp_in;
   logic [NCH-1:0]             trig_in;
   logic [NCH-1:0]             clr_in;
   logic [NCH-1:0][SAMP_W-1:0] avg;
   logic [NCH-1:0][SAMP_W-1:0] peak;
   logic [NCH-1:0]             busy;
   logic [NCH-1:0]             armed;
   logic [NCH-1:0]             full;

   assign samp_in = {power_sample_in, voltage_sample_in};
   assign trig_in = {power_period_trigger_input, voltage_period_trigger_input};
   assign clr_in  = {power_demand_clear, voltage_average_clear};

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ctrl <= CTRL_RST;
         dur  <= {DUR_RST, DUR_RST};
      end else if (wr_in) begin
         case (addr_in)
            OFS_CTRL:      ctrl   <= wdata_in[CTRL_W-1:0];
            OFS_VOLT_DUR:  dur[0] <= wdata_in[DUR_W-1:0];
            OFS_POWER_DUR: dur[1] <= wdata_in[DUR_W-1:0];
            default: ;
         endcase
      end
   end

   // direct control clear is a one-cycle pulse from a write to the command word
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cmd_clr <= '0;
      end else begin
         cmd_clr <= (wr_in && addr_in == OFS_CMD) ? wdata_in[CMD_W-1:0] : '0;
      end
   end

   // -------------------------------------------------------------
   // register read
   // -------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_out <= '0;
      end else if (rd_in) begin
         case (addr_in)
            OFS_CTRL:      rdata_out <= {28'h0, ctrl};
            OFS_VOLT_DUR:  rdata_out <= {13'h0, dur[0]};
            OFS_POWER_DUR: rdata_out <= {13'h0, dur[1]};
            OFS_VOLT_AVG:  rdata_out <= {16'h0, avg[0]};
            OFS_POWER_AVG: rdata_out <= {16'h0, avg[1]};
            OFS_POWER_PK:  rdata_out <= {16'h0, peak[1]};
            OFS_STATUS:    rdata_out <= {26'h0, full, armed, busy};
            default:       rdata_out <= '0;
         endcase
      end else begin
         rdata_out <= '0;
      end
   end

   // -------------------------------------------------------------
   // per channel averaging
   // -------------------------------------------------------------
   genvar c;
   generate
      for (c = 0; c < NCH; c++) begin : g_ch
         logic               slide;
         logic               edge_src;
         logic [2:0]         lg;
         logic [4:0]         len;
         logic [CNT_W-1:0]   fix_len;
         logic               trig_q;
         logic               clr_q;
         logic               trig_rise;
         logic               clr_hit;
         logic               pend;
         logic [SAMP_W-1:0]  s_hold;
         logic [SAMP_W-1:0]  old;
         logic [RING_AW-1:0] wp;
         logic [4:0]         fill;
         logic [SUM_W-1:0]   sum;
         logic [CNT_W-1:0]   cnt;
         logic               go;
         logic [SUM_W-1:0]   go_dvd;
         logic [CNT_W-1:0]   go_dvs;
         logic [SUM_W-1:0]   next_sum;
         logic [CNT_W-1:0]   next_cnt;
         logic [4:0]         next_fill;
         logic [SUM_W-1:0]   dq;
         logic [CNT_W:0]     rem;
         logic [CNT_W-1:0]   dvs;
         logic [5:0]         step;
         logic [CNT_W:0]     trial;
         logic               done;
         logic               armed_q;

         assign slide     = ctrl[2*c+CTRL_SLIDE_BIT];
         assign edge_src  = ctrl[2*c+CTRL_EDGE_BIT];
         assign lg        = (dur[c][DUR_W-1:DUR_LG_LSB] > 3'(LG_MAX)) ? 3'(LG_MAX)
                                                                      : dur[c][DUR_W-1:DUR_LG_LSB];
         assign len       = 5'(1) << lg;
         assign fix_len   = (dur[c][CNT_W-1:0] == '0) ? CNT_W'(1) : dur[c][CNT_W-1:0];
         assign trig_rise = trig_in[c] & ~trig_q;
         assign clr_hit   = (clr_in[c] & ~clr_q) | cmd_clr[c];
         assign full[c]   = (fill == len);
         assign armed[c]  = armed_q;
         assign busy[c]   = (step != '0);

         always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               trig_q <= 1'b0;
               clr_q  <= 1'b0;
            end else begin
               trig_q <= trig_in[c];
               clr_q  <= clr_in[c];
            end
         end

         // sample capture; the ring read for the oldest word is issued alongside
         always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               pend   <= 1'b0;
               s_hold <= '0;
            end else begin
               pend <= sample_valid_in;
               if (sample_valid_in) begin
                  s_hold <= samp_in[c];
               end
            end
         end

         dac_ring_mem #(.W(SAMP_W), .AW(RING_AW)) u_ring (
            .clk_in   (clk_in),
            .rst_n_in (rst_n_in),
            .we_in    (pend && slide && !edge_src),
            .waddr_in (wp),
            .wdata_in (s_hold),
            .raddr_in (wp - len[RING_AW-1:0]),
            .rdata_out(old)
         );

         // accumulation and period completion
         always_comb begin
            next_sum  = sum;
            next_cnt  = cnt;
            next_fill = fill;
            go        = 1'b0;
            go_dvd    = sum;
            go_dvs    = cnt;
            if (edge_src) begin
               if (trig_rise) begin
                  go        = armed_q && (cnt != '0);
                  next_sum  = '0;
                  next_cnt  = '0;
               end
               if (pend) begin
                  next_sum = next_sum + SUM_W'(s_hold);
                  next_cnt = (next_cnt == '1) ? next_cnt : next_cnt + CNT_W'(1);
               end
            end else if (slide) begin
               if (pend) begin
                  next_sum  = sum + SUM_W'(s_hold) - (full[c] ? SUM_W'(old) : '0);
                  next_fill = full[c] ? fill : fill + 5'(1);
                  go        = (next_fill == len);
                  go_dvd    = next_sum;
                  go_dvs    = CNT_W'(len);
               end
            end else if (pend) begin
               next_sum = sum + SUM_W'(s_hold);
               next_cnt = cnt + CNT_W'(1);
               if (next_cnt >= fix_len) begin
                  go       = 1'b1;
                  go_dvd   = next_sum;
                  go_dvs   = next_cnt;
                  next_sum = '0;
                  next_cnt = '0;
               end
            end
         end

         always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               sum     <= '0;
               cnt     <= '0;
               fill    <= '0;
               wp      <= '0;
               armed_q <= 1'b0;
            end else if (clr_hit) begin
               sum     <= '0;
               cnt     <= '0;
               fill    <= '0;
               armed_q <= 1'b0;
            end else begin
               sum  <= next_sum;
               cnt  <= next_cnt;
               fill <= next_fill;
               if (pend && slide && !edge_src) begin
                  wp <= wp + RING_AW'(1);
               end
               if (edge_src && trig_rise) begin
                  armed_q <= 1'b1;
               end
            end
         end

         // restoring divider: one quotient bit a cycle
         assign trial = {rem[CNT_W-1:0], dq[SUM_W-1]};
         assign done  = (step == 6'(1));

         always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               step <= '0;
               dq   <= '0;
               rem  <= '0;
               dvs  <= '0;
            end else if (clr_hit) begin
               step <= '0;
            end else if (go) begin
               step <= 6'(DIV_STEPS);
               dq   <= go_dvd;
               rem  <= '0;
               dvs  <= go_dvs;
            end else if (step != '0) begin
               step <= step - 6'(1);
               if (trial >= {1'b0, dvs}) begin
                  rem <= trial - {1'b0, dvs};
                  dq  <= {dq[SUM_W-2:0], 1'b1};
               end else begin
                  rem <= trial;
                  dq  <= {dq[SUM_W-2:0], 1'b0};
               end
            end
         end

         // completed average and peak demand
         always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               avg[c]  <= '0;
               peak[c] <= '0;
            end else if (clr_hit) begin
               avg[c]  <= '0;
               peak[c] <= '0;
            end else if (done) begin
               avg[c] <= {dq[SAMP_W-2:0], (trial >= {1'b0, dvs})};
               if (c == CH_POWER &&
                   {dq[SAMP_W-2:0], (trial >= {1'b0, dvs})} > peak[c]) begin
                  peak[c] <= {dq[SAMP_W-2:0], (trial >= {1'b0, dvs})};
               end
            end
         end
      end
   endgenerate
endmodule : dac_core

// ---- sim/dac_core_assertions.sv ----
// checker for the demand averaging block, watching only its top-level ports
// assumes one clock domain and the register map of dac_pkg
`timescale 1ns/1ps
module dac_core_checker
   import dac_pkg::*;
(
   input  wire logic              clk_in,
   input  wire logic              rst_n_in,
   input  wire logic [7:0]        addr_in,
   input  wire logic [31:0]       wdata_in,
   input  wire logic              wr_in,
   input  wire logic              rd_in,
   input  wire logic [31:0]       rdata_out,
   input  wire logic              sample_valid_in,
   input  wire logic [SAMP_W-1:0] voltage_sample_in,
   input  wire logic [SAMP_W-1:0] power_sample_in,
   input  wire logic              voltage_period_trigger_input,
   input  wire logic              power_period_trigger_input,
   input  wire logic              voltage_average_clear,
   input  wire logic              power_demand_clear
);
   // ------------------------------------------------------------
   // cycles since anything that may move a stored result
   // ------------------------------------------------------------
   logic [5:0] quiet;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         quiet <= 6'h00;
      end else if (sample_valid_in | voltage_period_trigger_input | power_period_trigger_input
                   | voltage_average_clear | power_demand_clear | wr_in) begin
         quiet <= 6'h00;
      end else if (quiet != 6'h3f) begin
         quiet <= quiet + 6'h01;
      end
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   AST_RD_IDLE: assert property (!rd_in |=> rdata_out == 32'h0)
      else $error("read data not zero outside a read answer");
   AST_VCLR_PIN: assert property ($rose(voltage_average_clear) ##[2:5]
      (rd_in && addr_in == OFS_VOLT_AVG) |=> rdata_out == 32'h0)
      else $error("voltage average survives its clear input");
   AST_PCLR_PIN: assert property ($rose(power_demand_clear) ##[2:5]
      (rd_in && (addr_in == OFS_POWER_AVG || addr_in == OFS_POWER_PK)) |=> rdata_out == 32'h0)
      else $error("power values survive their clear input");
   AST_VCMD: assert property ((wr_in && addr_in == OFS_CMD && wdata_in[0]) ##[2:4]
      (rd_in && addr_in == OFS_VOLT_AVG) |=> rdata_out == 32'h0)
      else $error("voltage average survives the clear command");
   AST_PCMD: assert property ((wr_in && addr_in == OFS_CMD && wdata_in[1]) ##[2:4]
      (rd_in && (addr_in == OFS_POWER_AVG || addr_in == OFS_POWER_PK)) |=> rdata_out == 32'h0)
      else $error("power values survive the clear command");
   AST_HOLD: assert property ((quiet > 6'd40 && rd_in && addr_in == OFS_POWER_PK) ##1
      (rd_in && addr_in == OFS_POWER_PK) |=> rdata_out == $past(rdata_out))
      else $error("peak moved with no completed average");
   AST_CTRL_RB: assert property ((wr_in && addr_in == OFS_CTRL) ##1
      (rd_in && addr_in == OFS_CTRL) |=> rdata_out == ($past(wdata_in, 2) & 32'hf))
      else $error("control readback differs from the write");
   AST_DUR_RB: assert property ((wr_in && (addr_in == OFS_VOLT_DUR ||
      addr_in == OFS_POWER_DUR)) ##1 (rd_in && addr_in == $past(addr_in))
      |=> rdata_out == ($past(wdata_in, 2) & 32'h7ffff))
      else $error("duration readback differs from the write");
endmodule : dac_core_checker

bind dac_core dac_core_checker u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
   .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
   .sample_valid_in(sample_valid_in), .voltage_sample_in(voltage_sample_in),
   .power_sample_in(power_sample_in),
   .voltage_period_trigger_input(voltage_period_trigger_input),
   .power_period_trigger_input(power_period_trigger_input),
   .voltage_average_clear(voltage_average_clear), .power_demand_clear(power_demand_clear));

// ---- sim/tb.sv ----
// self-checking bench for the demand averaging block
// assumes the register map of dac_pkg; the checker is bound from its own file
`timescale 1ns/1ps
module tb
   import dac_pkg::*;
;
   logic              clk_in, rst_n_in, wr_in, rd_in, sv, vtrig, ptrig, vclr, pclr, rd_d, armed;
   logic [7:0]        addr_in;
   logic [31:0]       wdata_in, rdata_out, e, pk, seed = 32'd41042;
   logic [SAMP_W-1:0] vs, ps;
   logic [31:0]       exp_q[$];
   logic [31:0]       sm[2], av[2];
   logic [15:0]       prev[2];
   logic              hv[2];
   int                n[2], dur[2], mode, err_total, num_checks;

   dac_core u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .sample_valid_in(sv),
      .voltage_sample_in(vs), .power_sample_in(ps), .voltage_period_trigger_input(vtrig),
      .power_period_trigger_input(ptrig), .voltage_average_clear(vclr),
      .power_demand_clear(pclr));

   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end
   // ------------------------------------------------------------
   // bus, stimulus and reference model
   // ------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic idle(input int c);
      rd_in <= 1'b0;
      wr_in <= 1'b0;
      repeat (c) @(posedge clk_in);
   endtask : idle
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      wr_in <= 1'b0;
      rd_in <= 1'b1;
      addr_in <= a;
      exp_q.push_back(x);
      @(posedge clk_in);
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      rd_in <= 1'b0;
      wr_in <= 1'b1;
      addr_in <= a;
      wdata_in <= d;
      @(posedge clk_in);
   endtask : wr
   task automatic chk(input int w);
      idle(w);
      rd(OFS_VOLT_AVG, av[0]);
      rd(OFS_POWER_AVG, av[1]);
      rd(OFS_POWER_PK, pk);
      rd(OFS_POWER_PK, pk);
      idle(2);
   endtask : chk
   task automatic clr(input int c);
      sm[c] = 0;
      n[c] = 0;
      av[c] = 0;
      hv[c] = 1'b0;
      armed = 1'b0;
      if (c == 1) pk = 0;
   endtask : clr
   task automatic fin(input int c);
      if (n[c] == 0) return;
      av[c] = sm[c] / n[c];
      if (c == 1 && av[c] > pk) pk = av[c];
      sm[c] = 0;
      n[c] = 0;
   endtask : fin
   task automatic model(input int c, input logic [15:0] v);
      if (mode == 1) begin
         if (hv[c]) begin
            sm[c] = prev[c] + v;
            n[c] = 2;
            fin(c);
         end
         prev[c] = v;
         hv[c] = 1'b1;
      end else begin
         sm[c] += v;
         n[c]++;
         if (mode == 0 && n[c] == dur[c]) fin(c);
      end
   endtask : model
   task automatic smp();
      sv <= 1'b1;
      vs <= 16'(rnd());
      ps <= 16'(rnd());
      idle(1);
      sv <= 1'b0;
      model(0, vs);
      model(1, ps);
      idle(39);
   endtask : smp
   task automatic trig();
      vtrig <= 1'b1;
      ptrig <= 1'b1;
      idle(1);
      vtrig <= 1'b0;
      ptrig <= 1'b0;
      if (armed) begin
         fin(0);
         fin(1);
      end
      sm = '{0, 0};
      n = '{0, 0};
      armed = 1'b1;
      idle(3);
   endtask : trig
   task automatic pin(input int c);
      if (c == 1) pclr <= 1'b1; else vclr <= 1'b1;
      idle(1);
      pclr <= 1'b0;
      vclr <= 1'b0;
      clr(c);
      idle(1);
   endtask : pin
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : final_report
   // ------------------------------------------------------------
   // read answers checked against the oldest expectation
   // ------------------------------------------------------------
   always @(posedge clk_in) begin
      if (rd_d) begin
         num_checks++;
         e = exp_q.pop_front();
         if (rdata_out !== e) begin
            err_total++;
            $display("ERROR %0t read data %h expected %h", $time, rdata_out, e);
         end
      end
      rd_d <= rd_in;
   end
   initial begin
      repeat (4000) @(posedge clk_in);
      err_total++;
      final_report();
   end
   initial begin
      {rst_n_in, wr_in, rd_in, sv, vtrig, ptrig, vclr, pclr} = '0;
      {addr_in, wdata_in, vs, ps, err_total, num_checks, mode} = '0;
      clr(0);
      clr(1);
      repeat (6) @(posedge clk_in);
      rst_n_in <= 1'b1;
      @(posedge clk_in);
      rd(OFS_CTRL, 32'h0);
      rd(OFS_VOLT_DUR, 32'(DUR_RST));
      rd(OFS_POWER_DUR, 32'(DUR_RST));
      rd(8'h20, 32'h0);
      chk(0);
      $display("test reset done");
      dur = '{2, 3};
      wr(OFS_POWER_DUR, 32'h3);
      wr(OFS_VOLT_DUR, 32'h2);
      rd(OFS_VOLT_DUR, 32'h2);
      idle(2);
      repeat (6) smp();
      chk(40);
      wr(OFS_CMD, 32'h1);
      idle(1);
      clr(0);
      chk(0);
      wr(OFS_CMD, 32'h2);
      idle(1);
      clr(1);
      chk(0);
      $display("test fixed and command clear done");
      mode = 1;
      wr(OFS_CTRL, 32'h5);
      rd(OFS_CTRL, 32'h5);
      wr(OFS_POWER_DUR, 32'h10000);
      wr(OFS_VOLT_DUR, 32'h10000);
      wr(OFS_CMD, 32'h3);
      idle(2);
      repeat (4) smp();
      chk(40);
      rd(OFS_STATUS, 32'(2'b11) << STAT_FULL_LSB);
      pin(0);
      chk(0);
      pin(1);
      chk(0);
      $display("test sliding and clear inputs done");
      mode = 2;
      wr(OFS_CTRL, 32'hf);
      idle(2);
      trig();
      repeat (3) smp();
      trig();
      repeat (2) smp();
      trig();
      chk(40);
      rd(OFS_STATUS, 32'(2'b11) << STAT_ARM_LSB);
      idle(2);
      $display("test edge period done");
      final_report();
   end
endmodule : tb
